// ==== fpsi_panel.sv ====
/*
 * fpsi_panel: front panel lamps, power-up screen sequence, basic
 * screen channel follow and blinking-digit numeric entry.
 * assumes controller logic on the same clock writes channel states
 * over the register port; panel keys arrive raw from the operator.
 */
// What this block does
// - light second-channel lamp while channel two values are displayed
// - two-input: monitor lamps follow channel one, or channel two when lamp lit
// - light measured-value lamp while channel-one measured shows on lower display
// - run lamp blinks in program standby, steady during execution
// - pause lamp steady while paused, blinks on input error while running
// - hand-output lamp blinks while output is in manual
// - constant-setpoint lamp lit while in fixed-value mode
// - event and digital-output lamps lit exactly while their action is active
// - remote-pattern lamp lit when 2 to 5 select bits assigned
// - serial-link lamp lit while setup runs over the communication link
// - self-tuning lamp blinks while tuning runs, steady in tuning standby
// - analog control outputs: lamp brightness by duty proportional to level
// - contact or SSR outputs: lamp on while output on, off otherwise
// - each power-up screen shown about three seconds, then basic screen
// - power-up order: name, io types, options, then basic screen
// - two-loop: group key back to basic follows displayed measured channel
// - first shift or up/down key makes least significant digit blink
// - commit key stores the edited value and stops blinking
`timescale 1ns/1ps
`default_nettype none
module fpsi_panel
    import fpsi_pkg::*;
#(
    parameter logic [24:0] BOOT_HOLD_CYCLES = BOOT_HOLD_CYC,
    parameter logic [24:0] BLINK_CYCLES     = BLINK_HALF_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    output logic             irq,
    input  wire logic        disp_key,
    input  wire logic        screen_group_key,
    input  wire logic        shift_key,
    input  wire logic        up_key,
    input  wire logic        down_key,
    input  wire logic        commit_key,
    output logic      [4:0]  screen_sel,
    output logic      [1:0]  display_mode,
    output logic             basic_channel_two,
    output logic      [15:0] edit_digits,
    output logic      [3:0]  digit_blink,
    output logic             second_channel_lamp,
    output logic             measured_value_lamp,
    output logic             program_run_lamp,
    output logic             pause_lamp,
    output logic             hand_output_lamp,
    output logic             constant_setpoint_lamp,
    output logic      [2:0]  event_action_lamp,
    output logic      [4:0]  digital_output_lamp,
    output logic             remote_pattern_select_lamp,
    output logic             serial_link_lamp,
    output logic             self_tuning_lamp,
    output logic             control_output_one_lamp,
    output logic             control_output_two_lamp
);
    // key synchroniser and edge detect
    logic [5:0] sync1_reg, sync2_reg, prev_reg;
    logic [5:0] key_edge;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            prev_reg  <= 6'h00;
        end else begin
            sync1_reg <= {commit_key, down_key, up_key, shift_key,
                          screen_group_key, disp_key};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
    always_comb begin
        key_edge = sync2_reg & ~prev_reg;
    end
    logic k_disp, k_grp, k_shift, k_up, k_down, k_commit;
    assign {k_commit, k_down, k_up, k_shift, k_grp, k_disp} = key_edge;

    // blink divider and duty counter
    logic [24:0] blink_cnt_reg, blink_cnt_next;
    logic        blink_reg, blink_next;
    logic [7:0]  pwm_reg, pwm_next;
    always_comb begin
        pwm_next       = pwm_reg + 8'h01;
        blink_cnt_next = blink_cnt_reg + 25'h0000001;
        blink_next     = blink_reg;
        if (blink_cnt_reg >= BLINK_CYCLES - 25'h0000001) begin
            blink_cnt_next = 25'h0000000;
            blink_next     = ~blink_reg;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_reg <= 25'h0000000;
            blink_reg     <= 1'b0;
            pwm_reg       <= 8'h00;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg     <= blink_next;
            pwm_reg       <= pwm_next;
        end
    end

    // software registers
    logic [CTL_WIDTH-1:0] ctrl_reg, ctrl_next;
    logic [7:0]           ch1_reg, ch1_next, ch2_reg, ch2_next;
    logic [ACT_WIDTH-1:0] act_reg, act_next;
    logic [15:0]          level_reg, level_next;
    logic [IRQ_WIDTH-1:0] istat_reg, istat_next, imask_reg, imask_next;
    logic [IRQ_WIDTH-1:0] ev_set;
    logic [31:0]          rdata_reg, rdata_next;

    // screen and edit state
    fpsi_screen_t scr_reg, scr_next;
    logic [24:0]  hold_reg, hold_next;
    logic [1:0]   mode_reg, mode_next;
    logic         bch_reg, bch_next;
    logic         edit_reg, edit_next;
    logic [1:0]   dig_reg, dig_next;
    logic [15:0]  val_reg, val_next, commit_reg, commit_next;

    function automatic logic [3:0] bcd_step(input logic [3:0] d, input logic up);
        logic [3:0] r;
        r = d;
        if (up) begin
            r = (d >= 4'h9) ? 4'h0 : d + 4'h1;
        end else begin
            r = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
        end
        return r;
    endfunction

    always_comb begin
        scr_next    = scr_reg;
        hold_next   = hold_reg;
        mode_next   = mode_reg;
        bch_next    = bch_reg;
        edit_next   = edit_reg;
        dig_next    = dig_reg;
        val_next    = val_reg;
        commit_next = commit_reg;
        ev_set      = '0;
        unique case (scr_reg)
            SCR_NAME, SCR_IO, SCR_OPT: begin
                hold_next = hold_reg + 25'h0000001;
                if (hold_reg >= BOOT_HOLD_CYCLES - 25'h0000001) begin
                    hold_next = 25'h0000000;
                    unique case (scr_reg)
                        SCR_NAME: scr_next = SCR_IO;
                        SCR_IO:   scr_next = SCR_OPT;
                        default:  scr_next = SCR_BASIC;
                    endcase
                    if (scr_reg == SCR_OPT) begin
                        ev_set[IRQ_BOOT_DONE] = 1'b1;
                    end
                end
            end
            SCR_BASIC: begin
                if (k_disp) begin
                    if (!ctrl_reg[CTL_TWO_LOOP] || mode_reg == DMODE_3) begin
                        mode_next = DMODE_1;
                    end else begin
                        mode_next = mode_reg + 2'h1;
                    end
                end else if (k_grp) begin
                    scr_next = SCR_GROUP;
                end
            end
            SCR_GROUP: begin
                if (k_grp && !edit_reg) begin
                    scr_next = SCR_BASIC;
                    ev_set[IRQ_GRP_RET] = 1'b1;
                    bch_next = ctrl_reg[CTL_TWO_LOOP] && mode_reg == DMODE_2;
                end else if (!edit_reg && (k_shift || k_up || k_down)) begin
                    edit_next = 1'b1;
                    dig_next  = 2'h0;
                    ev_set[IRQ_EDIT] = 1'b1;
                end else if (edit_reg && k_commit) begin
                    commit_next = val_reg;
                    edit_next   = 1'b0;
                    ev_set[IRQ_COMMIT] = 1'b1;
                end else if (edit_reg && k_shift) begin
                    dig_next = dig_reg + 2'h1;
                end else if (edit_reg && (k_up || k_down)) begin
                    val_next[dig_reg*4 +: 4] = bcd_step(val_reg[dig_reg*4 +: 4], k_up);
                end
            end
        endcase
        if (!ctrl_reg[CTL_TWO_LOOP]) begin
            mode_next = DMODE_1;
        end
        if (wr_stb && addr == OFS_EDIT && !edit_reg) begin
            val_next = wdata[15:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scr_reg    <= SCR_NAME;
            hold_reg   <= 25'h0000000;
            mode_reg   <= DMODE_1;
            bch_reg    <= 1'b0;
            edit_reg   <= 1'b0;
            dig_reg    <= 2'h0;
            val_reg    <= EDIT_RESET;
            commit_reg <= EDIT_RESET;
        end else begin
            scr_reg    <= scr_next;
            hold_reg   <= hold_next;
            mode_reg   <= mode_next;
            bch_reg    <= bch_next;
            edit_reg   <= edit_next;
            dig_reg    <= dig_next;
            val_reg    <= val_next;
            commit_reg <= commit_next;
        end
    end

    // register port
    always_comb begin
        ctrl_next  = ctrl_reg;
        ch1_next   = ch1_reg;
        ch2_next   = ch2_reg;
        act_next   = act_reg;
        level_next = level_reg;
        imask_next = imask_reg;
        istat_next = istat_reg;
        rdata_next = 32'h00000000;
        if (wr_stb) begin
            unique case (addr)
                OFS_CTRL:     ctrl_next  = wdata[CTL_WIDTH-1:0];
                OFS_CH1:      ch1_next   = wdata[7:0];
                OFS_CH2:      ch2_next   = wdata[7:0];
                OFS_ACTIONS:  act_next   = wdata[ACT_WIDTH-1:0];
                OFS_OUTLEVEL: level_next = wdata[15:0];
                OFS_IRQ_STAT: istat_next = istat_reg & ~wdata[IRQ_WIDTH-1:0];
                OFS_IRQ_MASK: imask_next = wdata[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
        // set wins over write-one clear
        istat_next = istat_next | ev_set;
        if (rd_stb) begin
            unique case (addr)
                OFS_CTRL:     rdata_next = {25'h0, ctrl_reg};
                OFS_CH1:      rdata_next = {24'h0, ch1_reg};
                OFS_CH2:      rdata_next = {24'h0, ch2_reg};
                OFS_ACTIONS:  rdata_next = {21'h0, act_reg};
                OFS_OUTLEVEL: rdata_next = {16'h0, level_reg};
                OFS_EDIT:     rdata_next = {16'h0, val_reg};
                OFS_COMMIT:   rdata_next = {16'h0, commit_reg};
                OFS_PANEL:    rdata_next = {20'h0, dig_reg, edit_reg, bch_reg,
                                            mode_reg, 1'b0, scr_reg};
                OFS_IRQ_STAT: rdata_next = {28'h0, istat_reg};
                OFS_IRQ_MASK: rdata_next = {28'h0, imask_reg};
                default:      rdata_next = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg  <= '0;
            ch1_reg   <= 8'h00;
            ch2_reg   <= 8'h00;
            act_reg   <= '0;
            level_reg <= 16'h0000;
            istat_reg <= '0;
            imask_reg <= '0;
            rdata_reg <= 32'h00000000;
        end else begin
            ctrl_reg  <= ctrl_next;
            ch1_reg   <= ch1_next;
            ch2_reg   <= ch2_next;
            act_reg   <= act_next;
            level_reg <= level_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            rdata_reg <= rdata_next;
        end
    end

    // lamp drive
    logic [24:0] lamp_reg, lamp_next;
    logic [7:0]  mon;
    logic        ch2_lit, pv_lit;
    logic [2:0]  sel_bits;
    always_comb begin
        ch2_lit  = mode_reg == DMODE_2;
        pv_lit   = mode_reg == DMODE_3;
        mon      = (ctrl_reg[CTL_TWO_INPUT] && ch2_lit) ? ch2_reg : ch1_reg;
        sel_bits = ctrl_reg[CTL_SEL_LSB +: 3];
        lamp_next = '0;
        lamp_next[0] = ch2_lit;
        lamp_next[1] = pv_lit;
        lamp_next[2] = mon[ST_RUN_EXEC] || (mon[ST_RUN_STBY] && blink_reg);
        lamp_next[3] = mon[ST_PAUSE] ||
                       (mon[ST_IN_ERR] && mon[ST_RUN_EXEC] && blink_reg);
        lamp_next[4] = mon[ST_MANUAL] && blink_reg;
        lamp_next[5] = mon[ST_FIX];
        lamp_next[8:6]   = act_reg[ACT_EV_LSB +: 3];
        lamp_next[13:9]  = act_reg[ACT_DO_LSB +: 5];
        lamp_next[14] = sel_bits >= SEL_BITS_MIN && sel_bits <= SEL_BITS_MAX;
        lamp_next[15] = act_reg[ACT_LINK];
        lamp_next[16] = mon[ST_AT_EXEC] ? blink_reg : mon[ST_AT_STBY];
        lamp_next[17] = ctrl_reg[CTL_CONTROL_OUTPUT_ONE_LAMP_ANA] ? (level_reg[7:0] > pwm_reg)
                                               : act_reg[ACT_CONTROL_OUTPUT_ONE_LAMP];
        lamp_next[18] = ctrl_reg[CTL_CONTROL_OUTPUT_TWO_LAMP_ANA] ? (level_reg[15:8] > pwm_reg)
                                               : act_reg[ACT_CONTROL_OUTPUT_TWO_LAMP];
        lamp_next[22:19] = (edit_reg && blink_reg) ? 4'(4'h1 << dig_reg) : 4'h0;
        lamp_next[23] = |(istat_reg & imask_reg);
        lamp_next[24] = 1'b0;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lamp_reg <= '0;
        end else begin
            lamp_reg <= lamp_next;
        end
    end

    assign second_channel_lamp        = lamp_reg[0];
    assign measured_value_lamp        = lamp_reg[1];
    assign program_run_lamp           = lamp_reg[2];
    assign pause_lamp                 = lamp_reg[3];
    assign hand_output_lamp           = lamp_reg[4];
    assign constant_setpoint_lamp     = lamp_reg[5];
    assign event_action_lamp          = lamp_reg[8:6];
    assign digital_output_lamp        = lamp_reg[13:9];
    assign remote_pattern_select_lamp = lamp_reg[14];
    assign serial_link_lamp           = lamp_reg[15];
    assign self_tuning_lamp           = lamp_reg[16];
    assign control_output_one_lamp    = lamp_reg[17];
    assign control_output_two_lamp    = lamp_reg[18];
    assign digit_blink                = lamp_reg[22:19];
    assign irq                        = lamp_reg[23];
    assign rdata                      = rdata_reg;
    assign screen_sel                 = scr_reg;
    assign display_mode               = mode_reg;
    assign basic_channel_two          = bch_reg;
    assign edit_digits                = val_reg;
endmodule
`default_nettype wire

// ==== fpsi_pkg.sv ====
/*
 * fpsi_pkg: constants for the front panel status indicator block:
 * register offsets, field positions, reset values, timing counts.
 * assumes a 10 MHz system clock and a 32-bit register port.
 */
`default_nettype none
package fpsi_pkg;
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned BOOT_SCREEN_MS = 3000;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam logic [24:0] BOOT_HOLD_CYC =
        25'(BOOT_SCREEN_MS * CYC_PER_MS);
    localparam logic [24:0] BLINK_HALF_CYC =
        25'(BLINK_HALF_MS * CYC_PER_MS);

    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CH1      = 8'h04;
    localparam logic [7:0] OFS_CH2      = 8'h08;
    localparam logic [7:0] OFS_ACTIONS  = 8'h0c;
    localparam logic [7:0] OFS_OUTLEVEL = 8'h10;
    localparam logic [7:0] OFS_EDIT     = 8'h14;
    localparam logic [7:0] OFS_COMMIT   = 8'h18;
    localparam logic [7:0] OFS_PANEL    = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

    // control register fields
    localparam int CTL_TWO_LOOP  = 0;
    localparam int CTL_TWO_INPUT = 1;
    localparam int CTL_CONTROL_OUTPUT_ONE_LAMP_ANA  = 2;
    localparam int CTL_CONTROL_OUTPUT_TWO_LAMP_ANA  = 3;
    localparam int CTL_SEL_LSB   = 4;
    localparam int CTL_WIDTH     = 7;
    localparam logic [2:0] SEL_BITS_MIN = 3'h2;
    localparam logic [2:0] SEL_BITS_MAX = 3'h5;

    // channel state fields
    localparam int ST_RUN_EXEC = 0;
    localparam int ST_RUN_STBY = 1;
    localparam int ST_PAUSE    = 2;
    localparam int ST_IN_ERR   = 3;
    localparam int ST_MANUAL   = 4;
    localparam int ST_FIX      = 5;
    localparam int ST_AT_EXEC  = 6;
    localparam int ST_AT_STBY  = 7;

    // action register fields
    localparam int ACT_EV_LSB = 0;
    localparam int ACT_DO_LSB = 3;
    localparam int ACT_CONTROL_OUTPUT_ONE_LAMP   = 8;
    localparam int ACT_CONTROL_OUTPUT_TWO_LAMP   = 9;
    localparam int ACT_LINK   = 10;
    localparam int ACT_WIDTH  = 11;

    // interrupt event bits
    localparam int IRQ_BOOT_DONE = 0;
    localparam int IRQ_GRP_RET   = 1;
    localparam int IRQ_EDIT      = 2;
    localparam int IRQ_COMMIT    = 3;
    localparam int IRQ_WIDTH     = 4;

    localparam logic [15:0] EDIT_RESET = 16'h0000;
    localparam logic [1:0]  DMODE_1    = 2'h0;
    localparam logic [1:0]  DMODE_2    = 2'h1;
    localparam logic [1:0]  DMODE_3    = 2'h2;

    typedef enum logic [4:0] {
        SCR_NAME  = 5'h01,
        SCR_IO    = 5'h02,
        SCR_OPT   = 5'h04,
        SCR_BASIC = 5'h08,
        SCR_GROUP = 5'h10
    } fpsi_screen_t;
endpackage
`default_nettype wire

// ==== fpsi_operator.sv ====
/* fpsi_operator: operator model that presses panel keys.
   assumes one-cycle press requests from the bench on clk. */
`timescale 1ns/1ps
`default_nettype none
module fpsi_operator #(
    parameter int HOLD = 4
) (
    input  wire logic       clk,
    input  wire logic [5:0] press_req,
    output logic      [5:0] keys
);
    int cnt = 0;
    // a press is held for several cycles, as a finger would
    always @(posedge clk) begin
        if (press_req != 6'h00) begin
            keys <= press_req;
            cnt  <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            keys <= 6'h00;
        end
    end
endmodule
`default_nettype wire

// ==== fpsi_panel_checker.sv ====
/* fpsi_panel_checker: assertions on panel outputs.
   assumes a bind to fpsi_panel; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module fpsi_panel_checker
    import fpsi_pkg::*;
#(
    parameter logic [24:0] BOOT_HOLD_CYCLES = BOOT_HOLD_CYC
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        rd_stb,
    input wire logic [31:0] rdata,
    input wire logic [4:0]  screen_sel,
    input wire logic [1:0]  display_mode,
    input wire logic        basic_channel_two,
    input wire logic [3:0]  digit_blink,
    input wire logic        second_channel_lamp,
    input wire logic        measured_value_lamp
);
    logic [4:0]  scr_prev_reg, scr_prev_next;
    logic [24:0] dwell_reg, dwell_next;
    logic        scr_chg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign scr_chg = screen_sel != scr_prev_reg;
    // cycles spent on the current screen
    always_comb begin
        scr_prev_next = screen_sel;
        dwell_next    = scr_chg ? 25'h0 : dwell_reg + 25'h1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scr_prev_reg <= 5'h01;
            dwell_reg    <= 25'h0;
        end else begin
            scr_prev_reg <= scr_prev_next;
            dwell_reg    <= dwell_next;
        end
    end
    sequence s_leave_boot;
        scr_chg && scr_prev_reg inside {5'h01, 5'h02, 5'h04};
    endsequence
    sequence s_leave(logic [4:0] s);
        scr_chg && scr_prev_reg == s;
    endsequence
    AST_BOOT_DWELL: assert property (s_leave_boot |-> dwell_reg >= BOOT_HOLD_CYCLES - 25'h3
        && dwell_reg <= BOOT_HOLD_CYCLES + 25'h1) else $error("boot screen dwell off");
    AST_NAME_TO_IO: assert property (s_leave(5'h01) |-> screen_sel == SCR_IO)
        else $error("name screen not followed by io screen");
    AST_IO_TO_OPT: assert property (s_leave(5'h02) |-> screen_sel == SCR_OPT)
        else $error("io screen not followed by option screen");
    AST_OPT_TO_BASIC: assert property (s_leave(5'h04) |-> screen_sel == SCR_BASIC)
        else $error("option screen not followed by basic screen");
    AST_CH2_LAMP: assert property (display_mode == DMODE_2 [*2] |->
        second_channel_lamp && !measured_value_lamp) else $error("ch2 lamp wrong");
    AST_PV_LAMP: assert property (display_mode == DMODE_3 [*2] |->
        measured_value_lamp && !second_channel_lamp) else $error("pv lamp wrong");
    AST_MODE1_DARK: assert property (display_mode == DMODE_1 [*2] |->
        !measured_value_lamp && !second_channel_lamp) else $error("mode1 lamps lit");
    AST_ONE_DIGIT: assert property ($onehot0(digit_blink))
        else $error("more than one digit blinking");
    AST_FOLLOW_CH: assert property ($changed(basic_channel_two) |-> screen_sel == SCR_BASIC)
        else $error("basic channel changed off basic screen");
    AST_RDATA_IDLE: assert property (!$past(rd_stb) |-> rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ==== front_panel_status_indicators_tb_top.sv ====
/* front_panel_status_indicators_tb_top: self-checking bench for fpsi_panel.
   assumes short boot and blink parameters; operator model drives keys. */
`timescale 1ns/1ps
`default_nettype none
module front_panel_status_indicators_tb_top;
    import fpsi_pkg::*;
    localparam int H = 20;
    logic clk, rst_n, wr_stb, rd_stb, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [5:0] press_req, keys;
    logic [4:0] screen_sel, dlamp;
    logic [1:0] display_mode;
    logic [15:0] edit_digits;
    logic [3:0] digit_blink;
    logic [2:0] elamp;
    logic bch2, l_ch2, l_pv, l_run, l_pause, l_hand, l_fix, l_ext, l_com, l_at, l_o1, l_o2;
    logic [17:0] st_tab [11] = '{18'h00401, 18'h00802, 18'h01004, 18'h02409, 18'h02000,
        18'h04020, 18'h08040, 18'h10200, 18'h20100, 18'h30200, 18'h03405};
    int n_errors = 0, checks = 0, n;
    fpsi_operator i_op (.clk(clk), .press_req(press_req), .keys(keys));
    fpsi_panel #(.BOOT_HOLD_CYCLES(25'h14), .BLINK_CYCLES(25'h4)) i_dut (.clk(clk),
        .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .irq(irq), .disp_key(keys[0]), .screen_group_key(keys[1]),
        .shift_key(keys[2]), .up_key(keys[3]), .down_key(keys[4]), .commit_key(keys[5]),
        .screen_sel(screen_sel), .display_mode(display_mode), .basic_channel_two(bch2),
        .edit_digits(edit_digits), .digit_blink(digit_blink), .second_channel_lamp(l_ch2),
        .measured_value_lamp(l_pv), .program_run_lamp(l_run), .pause_lamp(l_pause),
        .hand_output_lamp(l_hand), .constant_setpoint_lamp(l_fix), .event_action_lamp(elamp),
        .digital_output_lamp(dlamp), .remote_pattern_select_lamp(l_ext),
        .serial_link_lamp(l_com), .self_tuning_lamp(l_at), .control_output_one_lamp(l_o1),
        .control_output_two_lamp(l_o2));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic press(input int k);
        @(posedge clk);
        press_req <= 6'h01 << k;
        @(posedge clk);
        press_req <= 6'h00;
        cyc(10);
    endtask
    // ones seen on one lamp over k cycles
    task automatic count(input int idx, input int k, output int c);
        logic [6:0] v;
        c = 0;
        repeat (k) begin
            cyc(1);
            v = {digit_blink[0], l_o1, l_at, l_fix, l_hand, l_pause, l_run};
            c += int'(v[idx]);
        end
    endtask
    // code 0 dark, 1 steady, 2 blinking
    task automatic look(input int idx, input logic [1:0] code);
        int c;
        count(idx, 12, c);
        if (code == 2'h2) chk("blinking", 32'h1, 32'(c > 0 && c < 12));
        else chk("lamp ones", code == 2'h1 ? 32'd12 : 32'd0, 32'(c));
    endtask
    task automatic wait_scr(input logic [4:0] s);
        n = 0;
        while (screen_sel !== s && n < 40) begin
            cyc(1);
            n++;
        end
        chk("screen_sel", 32'(s), 32'(screen_sel));
    endtask
    initial begin
        #6_000_000;
        n_errors++;
        give_verdict();
    end
    initial begin
        {rst_n, wr_stb, rd_stb, addr, wdata, press_req} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        chk("screen_sel", 32'(SCR_NAME), 32'(screen_sel));
        wait_scr(SCR_IO);
        wait_scr(SCR_OPT);
        chk("boot dwell", 32'h1, 32'(n >= H - 2 && n <= H + 1));
        wait_scr(SCR_BASIC);
        rd(OFS_IRQ_STAT, d);
        chk("irq status", 32'h1, d);
        chk("irq", 32'h0, 32'(irq));
        wr(OFS_IRQ_MASK, 32'h1);
        cyc(3);
        chk("irq", 32'h1, 32'(irq));
        wr(OFS_IRQ_STAT, 32'h1);
        cyc(3);
        chk("irq", 32'h0, 32'(irq));
        rd(8'h40, d);
        chk("unmapped", 32'h0, d);
        for (int i = 0; i < 11; i++) begin
            wr(OFS_CH1, 32'(st_tab[i][17:10]));
            cyc(3);
            for (int j = 0; j < 5; j++) look(j, st_tab[i][2*j+:2]);
        end
        wr(OFS_CH1, 32'h0);
        for (int i = 0; i < 2; i++) begin
            wr(OFS_ACTIONS, i == 0 ? 32'h555 : 32'h2aa);
            cyc(3);
            chk("actions", i == 0 ? 32'h555 : 32'h2aa, 32'({l_com, l_o2, l_o1, dlamp, elamp}));
        end
        for (int k = 0; k < 8; k++) begin
            wr(OFS_CTRL, 32'(k << CTL_SEL_LSB));
            cyc(3);
            chk("remote lamp", 32'(k >= 2 && k <= 5), 32'(l_ext));
        end
        wr(OFS_CTRL, 32'h4);
        for (int k = 0; k < 3; k++) begin
            wr(OFS_OUTLEVEL, k == 0 ? 32'h0 : (k == 1 ? 32'h40 : 32'hff));
            cyc(3);
            count(5, 256, n);
            chk("control_output_one_lamp duty", k == 0 ? 32'h0 : (k == 1 ? 32'h40 : 32'hff), 32'(n));
        end
        wr(OFS_CTRL, 32'h3);
        wr(OFS_CH2, 32'h20);
        wr(OFS_ACTIONS, 32'h0);
        press(0);
        chk("mode", 32'({2'h3, DMODE_2}), 32'({l_fix, l_ch2, display_mode}));
        press(0);
        chk("mode", 32'({2'h1, DMODE_3}), 32'({l_fix, l_pv, display_mode}));
        press(0);
        chk("mode", 32'(DMODE_1), 32'({l_ch2, l_pv, display_mode}));
        press(0);
        press(1);
        chk("screen_sel", 32'(SCR_GROUP), 32'(screen_sel));
        press(1);
        chk("basic ch2", 32'({1'b1, SCR_BASIC}), 32'({bch2, screen_sel}));
        rd(OFS_IRQ_STAT, d);
        chk("irq status", 32'h2, d);
        wr(OFS_IRQ_STAT, 32'h2);
        press(1);
        wr(OFS_EDIT, 32'h1239);
        press(2);
        look(6, 2'h2);
        press(3);
        chk("edit", 32'h1230, 32'(edit_digits));
        press(4);
        chk("edit", 32'h1239, 32'(edit_digits));
        press(2);
        press(3);
        chk("edit", 32'h1249, 32'(edit_digits));
        press(5);
        rd(OFS_COMMIT, d);
        chk("commit", 32'h1249, d);
        look(6, 2'h0);
        give_verdict();
    end
endmodule
bind fpsi_panel fpsi_panel_checker #(.BOOT_HOLD_CYCLES(BOOT_HOLD_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .rd_stb(rd_stb), .rdata(rdata), .screen_sel(screen_sel),
    .display_mode(display_mode), .basic_channel_two(basic_channel_two),
    .digit_blink(digit_blink), .second_channel_lamp(second_channel_lamp),
    .measured_value_lamp(measured_value_lamp));
`default_nettype wire
